/* File: logic/rsom_defines.vh */
`ifndef RSOM_DEFINES_VH
`define RSOM_DEFINES_VH
// Operation
// [R1] error number ranges set error, critical, warning
// [R2] routine shown as 6-bit binary, main is zero
// [R3] heartbeat output echoes heartbeat input level
// [R4] master toggles heartbeat and checks the echo
// [R5] halt count increments once per emergency stop
// [R6] selector zero means all, 1-16 one robot
// [R7] master waits 40 ms after selector change
// [R8] drives energized: OR of all, else selected
// [R9] parked position: AND of all, else selected
// [R10] full power: any robot, else selected only
// [R11] calibration pending: any robot, else selected
// [R12] force regulation: any robot, else selected
// [R13] pose outputs give selected robot Z U V W
// [R14] joint effort outputs give selected robot torques
// [R15] load output shows user program load ratio
// [R16] controller and arm 16-bit wear words output
// [R17] integrator should use halt clear, not active
// [R18] no selector bits set reports robot one
// [R19] pose and torque are real-format words
// [R20] arm wear bits 1-6 used, others reserved
// [R21] master inputs pulse 25 ms, no overlap
// [R22] routine code held until next routine starts

// widths
`define RSOM_ERRW   14
`define RSOM_SELW   5
`define RSOM_UNITS  16
`define RSOM_WORDW  32
`define RSOM_BUSW   512
`define RSOM_CODEW  6
`define RSOM_CNTW   16
`define RSOM_LOADW  16
`define RSOM_WEARW  16

// error number ranges, inclusive
`define RSOM_ERR_LO   14'h03e8
`define RSOM_ERR_HI   14'h2327
`define RSOM_FATAL_LO 14'h2328
`define RSOM_FATAL_HI 14'h270f
`define RSOM_WARN_LO  14'h019a
`define RSOM_WARN_HI  14'h03e7

// selector encodings
`define RSOM_SEL_ALL  5'h00
`define RSOM_SEL_MAX  5'h10
`define RSOM_SEL_ONE  5'h01

// wear word masks, reserved bits forced low
`define RSOM_WEAR_CTRL_MASK 16'h0002
`define RSOM_WEAR_ARM_MASK  16'h007e

// reset values
`define RSOM_CODE_RST  6'h00
`define RSOM_CNT_RST   16'h0000
`define RSOM_CNT_ONE   16'h0001
`define RSOM_WORD_RST  32'h0000_0000
`define RSOM_LOAD_RST  16'h0000
`define RSOM_WEAR_RST  16'h0000
`endif

/* File: logic/rsom_err_class.v */
`timescale 1ns/1ps
`include "rsom_defines.vh"

module rsom_err_class (
	// error number under test
	input  wire [`RSOM_ERRW-1:0] err_num,
	// classification
	output wire                  hit_error,
	output wire                  hit_fatal,
	output wire                  hit_warning
);

	function in_range;
		input [`RSOM_ERRW-1:0] v;
		input [`RSOM_ERRW-1:0] lo;
		input [`RSOM_ERRW-1:0] hi;
		begin
			in_range = (v >= lo) && (v <= hi);
		end
	endfunction

	assign hit_error   = in_range(err_num, `RSOM_ERR_LO, `RSOM_ERR_HI); // [R1]
	assign hit_fatal   = in_range(err_num, `RSOM_FATAL_LO,
		`RSOM_FATAL_HI); // [R1]
	assign hit_warning = in_range(err_num, `RSOM_WARN_LO,
		`RSOM_WARN_HI); // [R1]

endmodule

/* File: logic/rsom_unit_agg.v */
`timescale 1ns/1ps
`include "rsom_defines.vh"

module rsom_unit_agg (
	// selection
	input  wire [`RSOM_SELW-1:0]  unit_selector,
	// per-robot states, bit n is robot n+1
	input  wire [`RSOM_UNITS-1:0] motor_on_units,
	input  wire [`RSOM_UNITS-1:0] home_units,
	input  wire [`RSOM_UNITS-1:0] high_power_units,
	input  wire [`RSOM_UNITS-1:0] uncal_units,
	input  wire [`RSOM_UNITS-1:0] force_units,
	// aggregated flags
	output wire                   drives_energized,
	output wire                   parked_position,
	output wire                   full_power,
	output wire                   calibration_pending,
	output wire                   force_regulation
);

	// out-of-range selector codes fall back to all robots
	wire sel_all = (unit_selector == `RSOM_SEL_ALL) ||
		(unit_selector > `RSOM_SEL_MAX);
	wire [`RSOM_SELW-1:0] idx = unit_selector - `RSOM_SEL_ONE;

	function pick_bit;
		input [`RSOM_UNITS-1:0] v;
		input [`RSOM_SELW-1:0]  i;
		begin
			pick_bit = v[i[3:0]];
		end
	endfunction

	assign drives_energized = sel_all ? (|motor_on_units) :
		pick_bit(motor_on_units, idx); // [R6] [R8]
	assign parked_position = sel_all ? (&home_units) :
		pick_bit(home_units, idx); // [R9]
	assign full_power = sel_all ? (|high_power_units) :
		pick_bit(high_power_units, idx); // [R10]
	assign calibration_pending = sel_all ? (|uncal_units) :
		pick_bit(uncal_units, idx); // [R11]
	assign force_regulation = sel_all ? (|force_units) :
		pick_bit(force_units, idx); // [R12]

endmodule

/* File: logic/rsom_top.v */
`timescale 1ns/1ps
`include "rsom_defines.vh"

module rsom_top (
	// clock, reset, enable
	input  wire                   ref_clk,
	input  wire                   resetn,
	input  wire                   clk_en,

	// error reporting
	input  wire [`RSOM_ERRW-1:0]  err_num,
	input  wire                   err_valid,
	input  wire                   err_reset,
	output reg                    error_flag_q,
	output reg                    fatal_fault_flag_q,
	output reg                    warning_flag_q,

	// running routine
	input  wire                   routine_start,
	input  wire [`RSOM_CODEW-1:0] routine_id,
	output reg                    routine_code_bit0_q,
	output reg                    routine_code_bit1_q,
	output reg                    routine_code_bit2_q,
	output reg                    routine_code_bit3_q,
	output reg                    routine_code_bit4_q,
	output reg                    routine_code_bit5_q,

	// liveness echo
	input  wire                   heartbeat_in,
	output reg                    heartbeat_out_q,

	// emergency stop
	input  wire                   halt_state,
	input  wire                   powered,
	output reg  [`RSOM_CNTW-1:0]  halt_event_count_q,
	output reg                    halt_active_flag_q,
	output reg                    halt_clear_flag_q,

	// per-robot states
	input  wire [`RSOM_SELW-1:0]  unit_selector,
	input  wire [`RSOM_UNITS-1:0] motor_on_units,
	input  wire [`RSOM_UNITS-1:0] home_units,
	input  wire [`RSOM_UNITS-1:0] high_power_units,
	input  wire [`RSOM_UNITS-1:0] uncal_units,
	input  wire [`RSOM_UNITS-1:0] force_units,
	output reg                    drives_energized_flag_q,
	output reg                    parked_position_flag_q,
	output reg                    full_power_flag_q,
	output reg                    calibration_pending_flag_q,
	output reg                    force_regulation_flag_q,

	// per-robot real-format words, robot n at bits 32n-1:32n-32
	input  wire [`RSOM_BUSW-1:0]  pose_z_units,
	input  wire [`RSOM_BUSW-1:0]  pose_u_units,
	input  wire [`RSOM_BUSW-1:0]  pose_v_units,
	input  wire [`RSOM_BUSW-1:0]  pose_w_units,
	input  wire [`RSOM_BUSW-1:0]  effort_j1_units,
	input  wire [`RSOM_BUSW-1:0]  effort_j2_units,
	input  wire [`RSOM_BUSW-1:0]  effort_j3_units,
	input  wire [`RSOM_BUSW-1:0]  effort_j4_units,
	input  wire [`RSOM_BUSW-1:0]  effort_j5_units,
	input  wire [`RSOM_BUSW-1:0]  effort_j6_units,
	output reg  [`RSOM_WORDW-1:0] pose_axis_output_z_q,
	output reg  [`RSOM_WORDW-1:0] pose_axis_output_u_q,
	output reg  [`RSOM_WORDW-1:0] pose_axis_output_v_q,
	output reg  [`RSOM_WORDW-1:0] pose_axis_output_w_q,
	output reg  [`RSOM_WORDW-1:0] joint_effort_output_1_q,
	output reg  [`RSOM_WORDW-1:0] joint_effort_output_2_q,
	output reg  [`RSOM_WORDW-1:0] joint_effort_output_3_q,
	output reg  [`RSOM_WORDW-1:0] joint_effort_output_4_q,
	output reg  [`RSOM_WORDW-1:0] joint_effort_output_5_q,
	output reg  [`RSOM_WORDW-1:0] joint_effort_output_6_q,

	// load and maintenance
	input  wire [`RSOM_LOADW-1:0] user_load,
	input  wire [`RSOM_WEARW-1:0] controller_wear_in,
	input  wire [`RSOM_WEARW-1:0] arm_wear_in,
	output reg  [`RSOM_LOADW-1:0] load_output_q,
	output reg  [`RSOM_WEARW-1:0] controller_wear_word_q,
	output reg  [`RSOM_WEARW-1:0] arm_wear_word_q
);

	wire                   hit_error;
	wire                   hit_fatal;
	wire                   hit_warning;
	wire                   agg_drives;
	wire                   agg_parked;
	wire                   agg_power;
	wire                   agg_cal;
	wire                   agg_force;
	reg                    halt_prev_q;
	// next values, kept apart so the clocked blocks stay plain copies
	wire                   halt_rise;
	wire                   halt_active_d;
	wire                   halt_clear_d;
	wire [`RSOM_CNTW-1:0]  halt_event_count_d;
	reg                    error_flag_d;
	reg                    warning_flag_d;
	reg                    fatal_fault_flag_d;
	reg  [`RSOM_CODEW-1:0] routine_code_d;

	rsom_err_class u_err (
		.err_num     (err_num),
		.hit_error   (hit_error),
		.hit_fatal   (hit_fatal),
		.hit_warning (hit_warning)
	);

	rsom_unit_agg u_agg (
		.unit_selector       (unit_selector),
		.motor_on_units      (motor_on_units),
		.home_units          (home_units),
		.high_power_units    (high_power_units),
		.uncal_units         (uncal_units),
		.force_units         (force_units),
		.drives_energized    (agg_drives),
		.parked_position     (agg_parked),
		.full_power          (agg_power),
		.calibration_pending (agg_cal),
		.force_regulation    (agg_force)
	);

	// robot index for word outputs; none or bad selection means robot one
	function [`RSOM_SELW-1:0] word_index;
		input [`RSOM_SELW-1:0] sel;
		begin
			if (sel == `RSOM_SEL_ALL || sel > `RSOM_SEL_MAX)
				word_index = `RSOM_SEL_ALL; // [R18]
			else
				word_index = sel - `RSOM_SEL_ONE;
		end
	endfunction

	function [`RSOM_WORDW-1:0] pick_word;
		input [`RSOM_BUSW-1:0] bus;
		input [`RSOM_SELW-1:0] sel;
		begin
			pick_word = bus[word_index(sel)*`RSOM_WORDW +: `RSOM_WORDW];
		end
	endfunction

	// error flags: error and warning cleared by reset input,
	// critical error only by a controller reset
	always @* begin
		error_flag_d       = error_flag_q;
		warning_flag_d     = warning_flag_q;
		fatal_fault_flag_d = fatal_fault_flag_q;
		if (err_reset) begin
			error_flag_d   = 1'b0;
			warning_flag_d = 1'b0;
		end
		// a new error in the clear cycle still sets
		if (err_valid && hit_error)
			error_flag_d = 1'b1; // [R1]
		if (err_valid && hit_warning)
			warning_flag_d = 1'b1; // [R1]
		// no clear for this one; only resetn drops it
		if (err_valid && hit_fatal)
			fatal_fault_flag_d = 1'b1; // [R1]
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			error_flag_q       <= 1'b0;
			fatal_fault_flag_q <= 1'b0;
			warning_flag_q     <= 1'b0;
		end else if (clk_en) begin
			error_flag_q       <= error_flag_d;
			fatal_fault_flag_q <= fatal_fault_flag_d;
			warning_flag_q     <= warning_flag_d;
		end
	end

	// routine code, held after the routine ends
	// a start while clk_en is low is lost
	always @* begin
		routine_code_d = {routine_code_bit5_q, routine_code_bit4_q,
			routine_code_bit3_q, routine_code_bit2_q,
			routine_code_bit1_q, routine_code_bit0_q};
		if (routine_start)
			routine_code_d = routine_id; // [R22]
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			routine_code_bit0_q <= 1'b0;
			routine_code_bit1_q <= 1'b0;
			routine_code_bit2_q <= 1'b0;
			routine_code_bit3_q <= 1'b0;
			routine_code_bit4_q <= 1'b0;
			routine_code_bit5_q <= 1'b0;
		end else if (clk_en) begin
			routine_code_bit0_q <= routine_code_d[0]; // [R2]
			routine_code_bit1_q <= routine_code_d[1];
			routine_code_bit2_q <= routine_code_d[2];
			routine_code_bit3_q <= routine_code_d[3];
			routine_code_bit4_q <= routine_code_d[4];
			routine_code_bit5_q <= routine_code_d[5];
		end
	end

	// one-cycle echo; the master's toggle period dwarfs this delay
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			heartbeat_out_q <= 1'b0;
		else if (clk_en)
			heartbeat_out_q <= heartbeat_in; // [R3]
	end

	// count wraps; a level held for many cycles counts once
	assign halt_rise          = halt_state & ~halt_prev_q;
	assign halt_event_count_d = halt_rise ?
		halt_event_count_q + `RSOM_CNT_ONE : halt_event_count_q; // [R5]
	// both low when unpowered, so only the clear flag tells
	// a released stop apart from power loss
	assign halt_active_d = powered & halt_state; // [R17]
	assign halt_clear_d  = powered & ~halt_state; // [R17]

	// emergency stop counting and state flags
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			halt_prev_q        <= 1'b0;
			halt_event_count_q <= `RSOM_CNT_RST;
			halt_active_flag_q <= 1'b0;
			halt_clear_flag_q  <= 1'b0;
		end else if (clk_en) begin
			halt_prev_q        <= halt_state;
			halt_event_count_q <= halt_event_count_d;
			halt_active_flag_q <= halt_active_d;
			halt_clear_flag_q  <= halt_clear_d;
		end
	end

	// selector-dependent flags; a selector change shows one edge later,
	// far inside the master's settling wait
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			drives_energized_flag_q    <= 1'b0;
			parked_position_flag_q     <= 1'b0;
			full_power_flag_q          <= 1'b0;
			calibration_pending_flag_q <= 1'b0;
			force_regulation_flag_q    <= 1'b0;
		end else if (clk_en) begin
			drives_energized_flag_q    <= agg_drives; // [R8]
			parked_position_flag_q     <= agg_parked; // [R9]
			full_power_flag_q          <= agg_power; // [R10]
			calibration_pending_flag_q <= agg_cal; // [R11]
			force_regulation_flag_q    <= agg_force; // [R12]
		end
	end

	// words pass through untouched, keeping their real format
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pose_axis_output_z_q    <= `RSOM_WORD_RST;
			pose_axis_output_u_q    <= `RSOM_WORD_RST;
			pose_axis_output_v_q    <= `RSOM_WORD_RST;
			pose_axis_output_w_q    <= `RSOM_WORD_RST;
			joint_effort_output_1_q <= `RSOM_WORD_RST;
			joint_effort_output_2_q <= `RSOM_WORD_RST;
			joint_effort_output_3_q <= `RSOM_WORD_RST;
			joint_effort_output_4_q <= `RSOM_WORD_RST;
			joint_effort_output_5_q <= `RSOM_WORD_RST;
			joint_effort_output_6_q <= `RSOM_WORD_RST;
		end else if (clk_en) begin
			pose_axis_output_z_q <=
				pick_word(pose_z_units, unit_selector); // [R13] [R19]
			pose_axis_output_u_q <=
				pick_word(pose_u_units, unit_selector); // [R13]
			pose_axis_output_v_q <=
				pick_word(pose_v_units, unit_selector); // [R13]
			pose_axis_output_w_q <=
				pick_word(pose_w_units, unit_selector); // [R13]
			joint_effort_output_1_q <=
				pick_word(effort_j1_units, unit_selector); // [R14] [R19]
			joint_effort_output_2_q <=
				pick_word(effort_j2_units, unit_selector); // [R14]
			joint_effort_output_3_q <=
				pick_word(effort_j3_units, unit_selector); // [R14]
			joint_effort_output_4_q <=
				pick_word(effort_j4_units, unit_selector); // [R14]
			joint_effort_output_5_q <=
				pick_word(effort_j5_units, unit_selector); // [R14]
			joint_effort_output_6_q <=
				pick_word(effort_j6_units, unit_selector); // [R14]
		end
	end

	// load and wear words; reserved wear bits read low
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			load_output_q          <= `RSOM_LOAD_RST;
			controller_wear_word_q <= `RSOM_WEAR_RST;
			arm_wear_word_q        <= `RSOM_WEAR_RST;
		end else if (clk_en) begin
			load_output_q <= user_load; // [R15]
			controller_wear_word_q <= controller_wear_in &
				`RSOM_WEAR_CTRL_MASK; // [R16]
			arm_wear_word_q <= arm_wear_in &
				`RSOM_WEAR_ARM_MASK; // [R16] [R20]
		end
	end

endmodule

/* File: sim/rsom_checker.sv */
`timescale 1ns/1ps
`include "rsom_defines.vh"
module rsom_checker (
	// clock and reset
	input wire                   ref_clk,
	input wire                   resetn,
	input wire                   clk_en,
	// error path
	input wire [`RSOM_ERRW-1:0]  err_num,
	input wire                   err_valid,
	input wire                   error_flag_q,
	input wire                   fatal_fault_flag_q,
	input wire                   warning_flag_q,
	// routine, echo, halt
	input wire                   routine_start,
	input wire [`RSOM_CODEW-1:0] routine_id,
	input wire                   routine_code_bit0_q,
	input wire                   routine_code_bit1_q,
	input wire                   routine_code_bit2_q,
	input wire                   routine_code_bit3_q,
	input wire                   routine_code_bit4_q,
	input wire                   routine_code_bit5_q,
	input wire                   heartbeat_in,
	input wire                   heartbeat_out_q,
	input wire                   halt_state,
	input wire [`RSOM_CNTW-1:0]  halt_event_count_q,
	// selection
	input wire [`RSOM_SELW-1:0]  unit_selector,
	input wire [`RSOM_UNITS-1:0] motor_on_units,
	input wire [`RSOM_UNITS-1:0] home_units,
	input wire                   drives_energized_flag_q,
	input wire                   parked_position_flag_q
);
	// low after reset or a frozen edge, so $past is trusted only when high
	reg        live_q;
	wire [5:0] code = {routine_code_bit5_q, routine_code_bit4_q,
		routine_code_bit3_q, routine_code_bit2_q, routine_code_bit1_q,
		routine_code_bit0_q};
	always @(posedge ref_clk or negedge resetn)
		if (!resetn)
			live_q <= 1'b0;
		else
			live_q <= clk_en;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_warn_range: assert property (live_q && $past(err_valid) &&
		$past(err_num) >= `RSOM_WARN_LO && $past(err_num) <= `RSOM_WARN_HI
		|-> warning_flag_q) else $error("warning flag missed");
	a_error_range: assert property (live_q && $past(err_valid) &&
		$past(err_num) >= `RSOM_ERR_LO && $past(err_num) <= `RSOM_ERR_HI
		|-> error_flag_q) else $error("error flag missed");
	a_fatal_range: assert property (live_q && $past(err_valid) &&
		$past(err_num) >= `RSOM_FATAL_LO &&
		$past(err_num) <= `RSOM_FATAL_HI
		|-> fatal_fault_flag_q) else $error("fatal flag missed");
	a_fatal_sticky: assert property (fatal_fault_flag_q
		|=> fatal_fault_flag_q) else $error("fatal flag dropped");
	a_code_load: assert property (live_q && $past(routine_start)
		|-> code == $past(routine_id)) else $error("routine code wrong");
	a_code_hold: assert property (live_q && !$past(routine_start)
		|-> $stable(code)) else $error("routine code moved");
	a_beat_echo: assert property (live_q
		|-> heartbeat_out_q == $past(heartbeat_in)) else $error("echo bad");
	a_halt_step: assert property (live_q && $past(live_q) &&
		$past(halt_state) && !$past(halt_state, 2) |-> halt_event_count_q
		== $past(halt_event_count_q) + `RSOM_CNT_ONE)
		else $error("halt count");
	a_any_motor: assert property (live_q &&
		$past(unit_selector) == `RSOM_SEL_ALL
		|-> drives_energized_flag_q == |$past(motor_on_units))
		else $error("drives flag not any-of");
	a_one_home: assert property (live_q &&
		$past(unit_selector) >= `RSOM_SEL_ONE &&
		$past(unit_selector) <= `RSOM_SEL_MAX |-> parked_position_flag_q ==
		$past(home_units[unit_selector - `RSOM_SEL_ONE]))
		else $error("parked bad");
	c_fatal: cover property (fatal_fault_flag_q);
	c_halt: cover property ($rose(halt_state) ##1 halt_event_count_q != 0);
	c_code: cover property (code == 6'h3f);
endmodule
bind rsom_top rsom_checker rsom_checker_i (.ref_clk(ref_clk),
	.resetn(resetn), .clk_en(clk_en), .err_num(err_num),
	.err_valid(err_valid), .error_flag_q(error_flag_q),
	.fatal_fault_flag_q(fatal_fault_flag_q),
	.warning_flag_q(warning_flag_q), .routine_start(routine_start),
	.routine_id(routine_id), .routine_code_bit0_q(routine_code_bit0_q),
	.routine_code_bit1_q(routine_code_bit1_q),
	.routine_code_bit2_q(routine_code_bit2_q),
	.routine_code_bit3_q(routine_code_bit3_q),
	.routine_code_bit4_q(routine_code_bit4_q),
	.routine_code_bit5_q(routine_code_bit5_q),
	.heartbeat_in(heartbeat_in), .heartbeat_out_q(heartbeat_out_q),
	.halt_state(halt_state), .halt_event_count_q(halt_event_count_q),
	.unit_selector(unit_selector), .motor_on_units(motor_on_units),
	.home_units(home_units),
	.drives_energized_flag_q(drives_energized_flag_q),
	.parked_position_flag_q(parked_position_flag_q));

/* File: sim/rsom_master_model.sv */
`timescale 1ns/1ps
module rsom_master_model #(
	parameter int HALF = 7
) (
	input  wire ref_clk,
	input  wire resetn,
	output reg  heartbeat_in
);
	int n;
	// odd half-period so toggles land at varied points of the bench's sequence
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			heartbeat_in <= 1'b0;
			n <= 0;
		end else if (n == HALF - 1) begin
			heartbeat_in <= ~heartbeat_in;
			n <= 0;
		end else begin
			n <= n + 1;
		end
	end
endmodule

/* File: sim/rsom_top_test.sv */
`timescale 1ns/1ps
`include "rsom_defines.vh"
module rsom_top_test;
	reg ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, err_valid = 1'b0;
	reg err_reset = 1'b0, routine_start = 1'b0, halt_state = 1'b0;
	reg powered = 1'b0;
	reg [13:0] err_num = 14'h0000;
	reg [5:0] routine_id = 6'h00;
	reg [4:0] unit_selector = 5'h00;
	reg [15:0] user_load = 16'h0000, cw = 16'h0000, aw = 16'h0000;
	reg [15:0] uv [0:4];
	reg [511:0] wb [0:9];
	wire heartbeat_in, ef, ff, wf, hbo, act, clr;
	wire [5:0] code;
	wire [15:0] cnt, lo, cwo, awo;
	wire [4:0] fl;
	wire [31:0] wo [0:9];
	int num_errors = 0, samples_checked = 0, i, k, p, s, r, fx = 0;
	int en [8] = '{409, 410, 999, 1000, 8999, 9000, 9999, 10000};
	reg b;
	always #5 ref_clk = ~ref_clk;
	rsom_master_model rsom_master_model_i (.ref_clk(ref_clk),
		.resetn(resetn), .heartbeat_in(heartbeat_in));
	rsom_top rsom_top_i (.ref_clk(ref_clk), .resetn(resetn),
		.clk_en(clk_en), .err_num(err_num), .err_valid(err_valid),
		.err_reset(err_reset), .error_flag_q(ef), .fatal_fault_flag_q(ff),
		.warning_flag_q(wf), .routine_start(routine_start),
		.routine_id(routine_id), .routine_code_bit0_q(code[0]),
		.routine_code_bit1_q(code[1]), .routine_code_bit2_q(code[2]),
		.routine_code_bit3_q(code[3]), .routine_code_bit4_q(code[4]),
		.routine_code_bit5_q(code[5]), .heartbeat_in(heartbeat_in),
		.heartbeat_out_q(hbo), .halt_state(halt_state), .powered(powered),
		.halt_event_count_q(cnt), .halt_active_flag_q(act),
		.halt_clear_flag_q(clr), .unit_selector(unit_selector),
		.motor_on_units(uv[0]), .home_units(uv[1]),
		.high_power_units(uv[2]), .uncal_units(uv[3]),
		.force_units(uv[4]), .drives_energized_flag_q(fl[4]),
		.parked_position_flag_q(fl[3]), .full_power_flag_q(fl[2]),
		.calibration_pending_flag_q(fl[1]), .force_regulation_flag_q(fl[0]),
		.pose_z_units(wb[0]), .pose_u_units(wb[1]), .pose_v_units(wb[2]),
		.pose_w_units(wb[3]), .effort_j1_units(wb[4]),
		.effort_j2_units(wb[5]), .effort_j3_units(wb[6]),
		.effort_j4_units(wb[7]), .effort_j5_units(wb[8]),
		.effort_j6_units(wb[9]), .pose_axis_output_z_q(wo[0]),
		.pose_axis_output_u_q(wo[1]), .pose_axis_output_v_q(wo[2]),
		.pose_axis_output_w_q(wo[3]), .joint_effort_output_1_q(wo[4]),
		.joint_effort_output_2_q(wo[5]), .joint_effort_output_3_q(wo[6]),
		.joint_effort_output_4_q(wo[7]), .joint_effort_output_5_q(wo[8]),
		.joint_effort_output_6_q(wo[9]), .user_load(user_load),
		.controller_wear_in(cw), .arm_wear_in(aw), .load_output_q(lo),
		.controller_wear_word_q(cwo), .arm_wear_word_q(awo));
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task summarize;
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#50000;
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize;
	end
	initial begin
		for (k = 0; k < 5; k++)
			uv[k] = 16'h0000;
		// word tags bus and robot so a wrong pick is visible
		for (k = 0; k < 10; k++)
			for (i = 0; i < 16; i++)
				wb[k][32*i +: 32] = 32'h5a000000 | (k << 8) | i;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		for (i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			err_num <= 14'(en[i]);
			err_valid <= 1'b1;
			@(posedge ref_clk);
			err_valid <= 1'b0;
			err_reset <= 1'b1;
			fx = fx | (en[i] >= 9000 && en[i] <= 9999);
			#1 chk(ef, en[i] >= 1000 && en[i] <= 8999);
			chk(wf, en[i] >= 410 && en[i] <= 999);
			chk(ff, fx);
			@(posedge ref_clk);
			err_reset <= 1'b0;
		end
		for (i = 0; i < 64; i++) begin
			@(posedge ref_clk);
			routine_start <= 1'b1;
			routine_id <= 6'(i);
			@(posedge ref_clk);
			routine_start <= 1'b0;
			routine_id <= 6'(~i);
			@(posedge ref_clk);
			#1 chk(code, i);
		end
		repeat (30) begin
			@(posedge ref_clk) b = heartbeat_in;
			#1 chk(hbo, b);
		end
		@(posedge ref_clk) powered <= 1'b1;
		for (i = 1; i <= 3; i++) begin
			@(posedge ref_clk) halt_state <= 1'b1;
			@(posedge ref_clk) halt_state <= 1'b0;
			#1 chk(cnt, i);
			chk({act, clr}, 2'h2);
			@(posedge ref_clk) #1 chk({act, clr}, 2'h1);
		end
		@(posedge ref_clk) powered <= 1'b0;
		@(posedge ref_clk) #1 chk({act, clr}, 2'h0);
		for (p = 0; p < 3; p++)
			for (s = 0; s < 18; s++) begin
				@(posedge ref_clk);
				unit_selector <= 5'(s);
				for (k = 0; k < 5; k++)
					uv[k] <= p == 1 ? 16'hffff : p == 2 ? 16'h0000 :
						16'h0f0f ^ (16'h1111 << k);
				repeat (2) @(posedge ref_clk);
				#1 r = (s >= 1 && s <= 16) ? s - 1 : 0;
				for (k = 0; k < 5; k++)
					chk(fl[4-k], (s >= 1 && s <= 16) ? uv[k][r] :
						k == 1 ? &uv[k] : |uv[k]);
				for (k = 0; k < 10; k++)
					chk(wo[k], wb[k][32*r +: 32]);
			end
		@(posedge ref_clk);
		user_load <= 16'hbeef;
		cw <= 16'hffff;
		aw <= 16'hffff;
		repeat (2) @(posedge ref_clk);
		#1 chk(lo, 16'hbeef);
		chk(cwo, 16'h0002);
		chk(awo, 16'h007e);
		// error and clear in one cycle: the error wins
		@(posedge ref_clk);
		err_num <= `RSOM_ERR_LO;
		err_valid <= 1'b1;
		err_reset <= 1'b1;
		@(posedge ref_clk);
		err_valid <= 1'b0;
		err_reset <= 1'b0;
		#1 chk(ef, 1'b1);
		// clk_en low freezes state and loses a routine start
		@(posedge ref_clk);
		clk_en <= 1'b0;
		user_load <= 16'h1234;
		routine_start <= 1'b1;
		routine_id <= 6'h15;
		repeat (2) @(posedge ref_clk);
		#1 chk(lo, 16'hbeef);
		chk(code, 6'h3f);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		routine_start <= 1'b0;
		// mid-run reset clears every flag, the critical one too
		@(posedge ref_clk) resetn <= 1'b0;
		@(posedge ref_clk) #1 chk(ff, 1'b0);
		chk(ef, 1'b0);
		chk(code, 6'h00);
		chk(cnt, 16'h0000);
		@(posedge ref_clk) resetn <= 1'b1;
		@(posedge ref_clk) halt_state <= 1'b1;
		@(posedge ref_clk) halt_state <= 1'b0;
		#1 chk(cnt, 16'h0001);
		summarize;
	end
endmodule
